// File: shared/acc_pkg.sv
// Operation
// - converter clock divides 16MHz to 2MHz, 1MHz, 500kHz or 250kHz, shared by ADC and DACs
// - ADC samples its input for 2, 4, 6 or 8 converter periods, then holds
// - one ADC conversion lasts three sample periods plus fourteen converter periods
// - single-shot and continuous modes; continuous restarts at once without software
// - 12-bit results from six channels: four external, temperature sensor, supply monitor
// - one-bit ADC gain: 0 spans zero to reference, 1 spans twice reference
// - one reference select for ADC and DACs; ADC and DAC gains independent
// - conversion end raises interrupt gated by enable; status bit can be polled
// - accumulator sums 2, 4, 8 or 16 consecutive results in continuous mode; software scales
// - with accumulation on, end of conversion flags only after the chosen count
// - supply monitor divider enabled only while measuring that channel
// - two 12-bit DAC channels, each with its own range setting
// - DAC conversion period follows the ADC formula on the shared divider
// - per-channel DAC busy indication readable by software
// - per-channel DAC enable; clearing it powers the cell down
// - after setup, a DAC update is only a write of the new value
// - both DACs convert together and alongside an ADC conversion
// - shared two-bit comparator hysteresis: 0, 10, 20 or 40 mV
// - comparator negative input: internal reference, matching DAC output, or external pin
// - comparator outputs readable, optional interrupt, per-comparator enable
// - low-power comparator mode, selectable wake edge; sleep needs external negative input
package acc_pkg;
    // register byte offsets
    localparam logic [7:0] ACC_OFS_CTRL = 8'h00;
    localparam logic [7:0] ACC_OFS_START = 8'h04;
    localparam logic [7:0] ACC_OFS_STAT = 8'h08;
    localparam logic [7:0] ACC_OFS_ADC_RES = 8'h0c;
    localparam logic [7:0] ACC_OFS_ACC_RES = 8'h10;
    localparam logic [7:0] ACC_OFS_DAC_CTRL = 8'h14;
    localparam logic [7:0] ACC_OFS_OUT_ONE_VAL = 8'h18;
    localparam logic [7:0] ACC_OFS_OUT_TWO_VAL = 8'h1c;
    localparam logic [7:0] ACC_OFS_CMP_CTRL = 8'h20;
    // control register fields
    localparam int ACC_CTRL_W = 14;
    localparam int ACC_CTRL_DIV = 0;
    localparam int ACC_CTRL_REF = 2;
    localparam int ACC_CTRL_GAIN = 3;
    localparam int ACC_CTRL_SMP = 4;
    localparam int ACC_CTRL_CONT = 6;
    localparam int ACC_CTRL_IEN = 7;
    localparam int ACC_CTRL_ACC_EN = 8;
    localparam int ACC_CTRL_ACC_N = 9;
    localparam int ACC_CTRL_CHAN = 11;
    localparam logic [13:0] ACC_CTRL_RST = 14'h0000;
    localparam int ACC_START_GO = 0;
    // status register fields
    localparam int ACC_STAT_BUSY = 0;
    localparam int ACC_STAT_EOC = 1;
    localparam int ACC_STAT_DAC_BUSY = 2;
    localparam int ACC_STAT_CMP_OUT = 4;
    localparam int ACC_STAT_CMP_EVT = 6;
    // dac control fields, channel n at bit 2n
    localparam int ACC_DACC_W = 4;
    localparam int ACC_DACC_EN = 0;
    localparam int ACC_DACC_RANGE = 1;
    localparam logic [3:0] ACC_DACC_RST = 4'h0;
    // comparator control fields, channel n offset by n (select fields by 2n)
    localparam int ACC_CMP_W = 15;
    localparam int ACC_CMP_HYS = 0;
    localparam int ACC_CMP_EN = 2;
    localparam int ACC_CMP_NEG = 4;
    localparam int ACC_CMP_LOWPWR = 8;
    localparam int ACC_CMP_IEN = 9;
    localparam int ACC_CMP_RISE = 11;
    localparam int ACC_CMP_WAKE = 13;
    localparam logic [14:0] ACC_CMP_RST = 15'h0000;
    // channel and select codes
    localparam logic [2:0] ACC_CHAN_TEMP = 3'h4;
    localparam logic [2:0] ACC_CHAN_SUPPLY = 3'h5;
    localparam logic [1:0] ACC_NEG_VREF = 2'h0;
    localparam logic [1:0] ACC_NEG_DAC = 2'h1;
    localparam logic [1:0] ACC_NEG_PIN = 2'h2;
    // timing
    localparam int ACC_SRC_HZ = 16000000;
    localparam int ACC_CONV_MAX_HZ = 2000000;
    localparam int ACC_DIV_HALF_MIN = ACC_SRC_HZ / ACC_CONV_MAX_HZ / 2;
    localparam int ACC_SMP_STEP = 2;
    localparam int ACC_CONV_MULT = 3;
    localparam int ACC_CONV_FIXED = 14;
    localparam int ACC_ACC_MIN = 2;
    typedef enum logic [1:0] {ADC_IDLE, ADC_SAMPLE, ADC_HOLD} acc_adc_e;
endpackage : acc_pkg

// File: verilog/acc_converter_control.sv
`timescale 1ns/1ps
`default_nettype none
module acc_converter_control
    import acc_pkg::*;
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic src_16m_tick,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // shared converter controls
    output logic conv_clk,
    output logic ref_sel,
    // adc macro
    output logic [2:0] adc_chan,
    output logic adc_gain,
    output logic adc_sample,
    output logic adc_busy,
    output logic supply_mon_en,
    input wire logic [11:0] adc_data,
    // dac macro
    output logic [11:0] analog_output_one_code,
    output logic analog_output_one_en,
    output logic analog_output_one_range,
    output logic analog_output_one_busy,
    output logic [11:0] analog_output_two_code,
    output logic analog_output_two_en,
    output logic analog_output_two_range,
    output logic analog_output_two_busy,
    // comparator macro
    input wire logic comparator_one,
    input wire logic comparator_two,
    output logic comparator_one_en,
    output logic comparator_two_en,
    output logic [1:0] comparator_one_negative_input,
    output logic [1:0] comparator_two_negative_input,
    output logic [1:0] cmp_hysteresis,
    output logic cmp_low_power,
    // events
    output logic adc_irq,
    output logic cmp_irq,
    output logic cmp_wake
);
    import acc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic wait_ff;
        logic [31:0] rdata;
        logic [13:0] ctrl;
        logic [3:0] dacc;
        logic [14:0] cmp;
        logic [1:0][11:0] dac_val;
        logic [5:0] div_cnt;
        logic cclk;
        logic tick;
        acc_adc_e adc_st;
        logic [5:0] adc_cnt;
        logic adc_done;
        logic sample_o;
        logic busy_o;
        logic supply_en;
        logic [11:0] adc_res;
        logic [15:0] acc_sum;
        logic [4:0] acc_n;
        logic eoc;
        logic adc_irq;
        logic [1:0] dac_busy;
        logic [1:0][5:0] dac_cnt;
        logic [1:0] cmp_s1;
        logic [1:0] cmp_s2;
        logic [1:0] cmp_prev;
        logic [1:0] cmp_evt;
        logic cmp_irq;
        logic wake;
    } acc_state_s;

    localparam acc_state_s ACC_ST_RST = '{
        wait_ff: 1'b1, rdata: 32'h0000_0000, ctrl: ACC_CTRL_RST, dacc: ACC_DACC_RST,
        cmp: ACC_CMP_RST, dac_val: 24'h00_0000, div_cnt: 6'h00, cclk: 1'b0, tick: 1'b0,
        adc_st: ADC_IDLE, adc_cnt: 6'h00, adc_done: 1'b0, sample_o: 1'b0, busy_o: 1'b0,
        supply_en: 1'b0, adc_res: 12'h000, acc_sum: 16'h0000, acc_n: 5'h00, eoc: 1'b0,
        adc_irq: 1'b0, dac_busy: 2'h0, dac_cnt: 12'h000, cmp_s1: 2'h0, cmp_s2: 2'h0,
        cmp_prev: 2'h0, cmp_evt: 2'h0, cmp_irq: 1'b0, wake: 1'b0};

    acc_state_s st_ff;
    acc_state_s nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // half converter period in 16MHz ticks
    function automatic logic [5:0] div_half(input logic [1:0] sel);
        div_half = 6'(ACC_DIV_HALF_MIN << sel);
    endfunction : div_half

    // sample window in converter periods
    function automatic logic [5:0] smp_len(input logic [1:0] sel);
        smp_len = 6'(ACC_SMP_STEP * (int'(sel) + 1));
    endfunction : smp_len

    // whole conversion in converter periods
    function automatic logic [5:0] conv_len(input logic [1:0] sel);
        conv_len = 6'(ACC_CONV_MULT * ACC_SMP_STEP * (int'(sel) + 1) + ACC_CONV_FIXED);
    endfunction : conv_len

    function automatic logic [4:0] acc_target(input logic [1:0] sel);
        acc_target = 5'(ACC_ACC_MIN << sel);
    endfunction : acc_target

    // byte-lane write merge
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        wmerge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                wmerge[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
    endfunction : wmerge

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] cmp_raw;
    assign cmp_raw = {comparator_two, comparator_one};

    always_comb begin
        logic req;
        logic wr;
        logic go;
        logic set_eoc;
        logic clr_eoc;
        logic [1:0] clr_evt;
        logic [1:0] wr_dac;
        logic [1:0] act;
        logic [1:0] smp;
        logic [31:0] tmp;
        req = (avs_read | avs_write) & st_ff.wait_ff;
        wr = req & avs_write;
        go = 1'b0;
        set_eoc = 1'b0;
        clr_eoc = 1'b0;
        clr_evt = 2'h0;
        wr_dac = 2'h0;
        act = 2'h0;
        smp = st_ff.ctrl[ACC_CTRL_SMP +: 2];
        tmp = 32'h0000_0000;
        nxt_st = st_ff;

        // bus slave: one wait cycle, answer on the following edge
        nxt_st.wait_ff = ~req;
        nxt_st.rdata = 32'h0000_0000;
        if (req && avs_read) begin
            case (avs_address)
                ACC_OFS_CTRL: nxt_st.rdata = {18'h0_0000, st_ff.ctrl};
                ACC_OFS_STAT: begin
                    nxt_st.rdata[ACC_STAT_BUSY] = st_ff.busy_o;
                    nxt_st.rdata[ACC_STAT_EOC] = st_ff.eoc;
                    nxt_st.rdata[ACC_STAT_DAC_BUSY +: 2] = st_ff.dac_busy;
                    nxt_st.rdata[ACC_STAT_CMP_OUT +: 2] = st_ff.cmp_s2;
                    nxt_st.rdata[ACC_STAT_CMP_EVT +: 2] = st_ff.cmp_evt;
                end
                ACC_OFS_ADC_RES: nxt_st.rdata = {20'h0_0000, st_ff.adc_res};
                ACC_OFS_ACC_RES: nxt_st.rdata = {16'h0000, st_ff.acc_sum};
                ACC_OFS_DAC_CTRL: nxt_st.rdata = {28'h000_0000, st_ff.dacc};
                ACC_OFS_OUT_ONE_VAL: nxt_st.rdata = {20'h0_0000, st_ff.dac_val[0]};
                ACC_OFS_OUT_TWO_VAL: nxt_st.rdata = {20'h0_0000, st_ff.dac_val[1]};
                ACC_OFS_CMP_CTRL: nxt_st.rdata = {17'h0_0000, st_ff.cmp};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (avs_address)
                ACC_OFS_CTRL: begin
                    tmp = wmerge({18'h0_0000, st_ff.ctrl}, avs_writedata, avs_byteenable);
                    nxt_st.ctrl = tmp[ACC_CTRL_W-1:0];
                    if (nxt_st.ctrl[ACC_CTRL_CHAN +: 3] > ACC_CHAN_SUPPLY) begin
                        nxt_st.ctrl[ACC_CTRL_CHAN +: 3] = ACC_CHAN_SUPPLY;
                    end
                end
                ACC_OFS_START: go = avs_byteenable[0] & avs_writedata[ACC_START_GO];
                ACC_OFS_STAT: begin
                    clr_eoc = avs_byteenable[0] & avs_writedata[ACC_STAT_EOC];
                    clr_evt = avs_byteenable[0] ? avs_writedata[ACC_STAT_CMP_EVT +: 2] : 2'h0;
                end
                ACC_OFS_DAC_CTRL: begin
                    tmp = wmerge({28'h000_0000, st_ff.dacc}, avs_writedata, avs_byteenable);
                    nxt_st.dacc = tmp[ACC_DACC_W-1:0];
                end
                ACC_OFS_OUT_ONE_VAL, ACC_OFS_OUT_TWO_VAL: begin
                    // a value write alone updates the channel and, while its enable bit is set, starts it
                    tmp = wmerge({20'h0_0000, st_ff.dac_val[avs_address[2]]}, avs_writedata, avs_byteenable);
                    nxt_st.dac_val[avs_address[2]] = tmp[11:0];
                    wr_dac[avs_address[2]] = 1'b1;
                end
                ACC_OFS_CMP_CTRL: begin
                    tmp = wmerge({17'h0_0000, st_ff.cmp}, avs_writedata, avs_byteenable);
                    nxt_st.cmp = tmp[ACC_CMP_W-1:0];
                end
                default: ;
            endcase
        end

        // converter clock divider, tick marks each rising edge
        nxt_st.tick = 1'b0;
        if (src_16m_tick) begin
            if (st_ff.div_cnt == div_half(st_ff.ctrl[ACC_CTRL_DIV +: 2]) - 6'h01) begin
                nxt_st.div_cnt = 6'h00;
                nxt_st.cclk = ~st_ff.cclk;
                nxt_st.tick = ~st_ff.cclk;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
            end
        end

        // adc sequencer, counted in converter periods
        nxt_st.adc_done = 1'b0;
        case (st_ff.adc_st)
            ADC_IDLE: begin
                if (go) begin
                    nxt_st.adc_st = ADC_SAMPLE;
                    nxt_st.adc_cnt = 6'h00;
                    nxt_st.acc_n = 5'h00;
                end
            end
            ADC_SAMPLE: begin
                if (st_ff.tick) begin
                    if (st_ff.adc_cnt == smp_len(smp) - 6'h01) begin
                        nxt_st.adc_st = ADC_HOLD;
                    end
                    nxt_st.adc_cnt = st_ff.adc_cnt + 6'h01;
                end
            end
            ADC_HOLD: begin
                if (st_ff.tick) begin
                    if (st_ff.adc_cnt == conv_len(smp) - 6'h01) begin
                        nxt_st.adc_done = 1'b1;
                        nxt_st.adc_res = adc_data;
                        nxt_st.adc_cnt = 6'h00;
                        // a fresh block starts from the new result alone
                        nxt_st.acc_sum = (st_ff.acc_n == 5'h00 ? 16'h0000 : st_ff.acc_sum)
                            + {4'h0, adc_data};
                        if (st_ff.ctrl[ACC_CTRL_ACC_EN]) begin
                            if (st_ff.acc_n == acc_target(st_ff.ctrl[ACC_CTRL_ACC_N +: 2]) - 5'h01) begin
                                set_eoc = 1'b1;
                                nxt_st.acc_n = 5'h00;
                            end else begin
                                nxt_st.acc_n = st_ff.acc_n + 5'h01;
                            end
                        end else begin
                            set_eoc = 1'b1;
                            nxt_st.acc_n = 5'h00;
                        end
                        nxt_st.adc_st = st_ff.ctrl[ACC_CTRL_CONT] ? ADC_SAMPLE : ADC_IDLE;
                    end else begin
                        nxt_st.adc_cnt = st_ff.adc_cnt + 6'h01;
                    end
                end
            end
            default: nxt_st.adc_st = ADC_IDLE;
        endcase
        nxt_st.sample_o = nxt_st.adc_st == ADC_SAMPLE;
        nxt_st.busy_o = nxt_st.adc_st != ADC_IDLE;
        // divider chain powered only during a supply measurement
        nxt_st.supply_en = nxt_st.busy_o && nxt_st.ctrl[ACC_CTRL_CHAN +: 3] == ACC_CHAN_SUPPLY;

        // set wins over a simultaneous clear
        nxt_st.eoc = (st_ff.eoc & ~clr_eoc) | set_eoc;
        nxt_st.adc_irq = nxt_st.eoc & nxt_st.ctrl[ACC_CTRL_IEN];

        // dac channels run independently of each other and of the adc
        for (int i = 0; i < 2; i++) begin
            if (!nxt_st.dacc[2*i + ACC_DACC_EN]) begin
                nxt_st.dac_busy[i] = 1'b0;
                nxt_st.dac_cnt[i] = 6'h00;
            end else if (wr_dac[i]) begin
                nxt_st.dac_busy[i] = 1'b1;
                nxt_st.dac_cnt[i] = 6'h00;
            end else if (st_ff.dac_busy[i] && st_ff.tick) begin
                if (st_ff.dac_cnt[i] == conv_len(smp) - 6'h01) begin
                    nxt_st.dac_busy[i] = 1'b0;
                end else begin
                    nxt_st.dac_cnt[i] = st_ff.dac_cnt[i] + 6'h01;
                end
            end
        end

        // comparators: two-stage sync, then edge detect
        nxt_st.cmp_s1 = cmp_raw;
        nxt_st.cmp_s2 = st_ff.cmp_s1;
        nxt_st.cmp_prev = st_ff.cmp_s2;
        nxt_st.wake = 1'b0;
        for (int i = 0; i < 2; i++) begin
            act[i] = st_ff.cmp[ACC_CMP_EN + i] && st_ff.cmp_s2[i] != st_ff.cmp_prev[i]
                && st_ff.cmp_s2[i] == st_ff.cmp[ACC_CMP_RISE + i];
            if (act[i] && st_ff.cmp[ACC_CMP_WAKE + i]) begin
                nxt_st.wake = 1'b1;
            end
        end
        nxt_st.cmp_evt = (st_ff.cmp_evt & ~clr_evt) | act;
        nxt_st.cmp_irq = |(nxt_st.cmp_evt & nxt_st.cmp[ACC_CMP_IEN +: 2]);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff <= ACC_ST_RST;
        end else if (clock_en) begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = st_ff.wait_ff;
    assign conv_clk = st_ff.cclk;
    assign ref_sel = st_ff.ctrl[ACC_CTRL_REF];
    assign adc_chan = st_ff.ctrl[ACC_CTRL_CHAN +: 3];
    assign adc_gain = st_ff.ctrl[ACC_CTRL_GAIN];
    assign adc_sample = st_ff.sample_o;
    assign adc_busy = st_ff.busy_o;
    assign supply_mon_en = st_ff.supply_en;
    assign analog_output_one_code = st_ff.dac_val[0];
    assign analog_output_one_en = st_ff.dacc[ACC_DACC_EN];
    assign analog_output_one_range = st_ff.dacc[ACC_DACC_RANGE];
    assign analog_output_one_busy = st_ff.dac_busy[0];
    assign analog_output_two_code = st_ff.dac_val[1];
    assign analog_output_two_en = st_ff.dacc[2 + ACC_DACC_EN];
    assign analog_output_two_range = st_ff.dacc[2 + ACC_DACC_RANGE];
    assign analog_output_two_busy = st_ff.dac_busy[1];
    assign comparator_one_en = st_ff.cmp[ACC_CMP_EN];
    assign comparator_two_en = st_ff.cmp[ACC_CMP_EN + 1];
    assign comparator_one_negative_input = st_ff.cmp[ACC_CMP_NEG +: 2];
    assign comparator_two_negative_input = st_ff.cmp[ACC_CMP_NEG + 2 +: 2];
    assign cmp_hysteresis = st_ff.cmp[ACC_CMP_HYS +: 2];
    assign cmp_low_power = st_ff.cmp[ACC_CMP_LOWPWR];
    assign adc_irq = st_ff.adc_irq;
    assign cmp_irq = st_ff.cmp_irq;
    assign cmp_wake = st_ff.wake;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset || !clock_en);

    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_div_edge: assert property ($rose(conv_clk) |-> $past(src_16m_tick) &&
        $past(st_ff.div_cnt) == div_half(st_ff.ctrl[ACC_CTRL_DIV +: 2]) - 6'h01)
        else $error("converter clock edge off the divider count");
    a_sample_to_hold: assert property (adc_sample && st_ff.tick
        && st_ff.adc_cnt == smp_len(st_ff.ctrl[ACC_CTRL_SMP +: 2]) - 6'h01 |=> !adc_sample && adc_busy)
        else $error("sample window did not end in hold");
    a_conv_length: assert property (st_ff.adc_done |->
        $past(st_ff.adc_cnt) == conv_len(st_ff.ctrl[ACC_CTRL_SMP +: 2]) - 6'h01)
        else $error("conversion ended at wrong period count");
    a_cont_restart: assert property (st_ff.adc_done && $past(st_ff.ctrl[ACC_CTRL_CONT]) |->
        adc_sample && st_ff.adc_cnt == 6'h00)
        else $error("continuous mode did not restart");
    a_chan_range: assert property (adc_chan <= ACC_CHAN_SUPPLY)
        else $error("channel select out of range");
    a_eoc_irq: assert property ($rose(st_ff.eoc) && st_ff.ctrl[ACC_CTRL_IEN] |-> adc_irq)
        else $error("enabled end of conversion gave no interrupt");
    a_acc_count: assert property ($rose(st_ff.eoc) && st_ff.ctrl[ACC_CTRL_ACC_EN] |->
        $past(st_ff.acc_n) == acc_target(st_ff.ctrl[ACC_CTRL_ACC_N +: 2]) - 5'h01)
        else $error("accumulated flag before sample count");
    a_supply_gate: assert property (supply_mon_en |-> adc_busy && adc_chan == ACC_CHAN_SUPPLY)
        else $error("supply divider on outside its measurement");
    a_dac_busy_len: assert property ($fell(analog_output_one_busy) && analog_output_one_en |->
        $past(st_ff.dac_cnt[0]) == conv_len(st_ff.ctrl[ACC_CTRL_SMP +: 2]) - 6'h01)
        else $error("dac period wrong length");
    a_cmp_synced: assert property ($rose(st_ff.cmp_evt[0]) |->
        $past(st_ff.cmp_s2[0]) != $past(st_ff.cmp_prev[0]))
        else $error("comparator event without synchronised edge");

    c_cont_done: cover property (st_ff.adc_done && st_ff.ctrl[ACC_CTRL_CONT]);
    c_acc_block: cover property ($rose(st_ff.eoc) && st_ff.ctrl[ACC_CTRL_ACC_EN]);
    c_dac_both: cover property (analog_output_one_busy && analog_output_two_busy && adc_busy);
    c_wake: cover property (cmp_wake);
endmodule : acc_converter_control
`default_nettype wire

// File: dv/acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    // from design
    input wire logic adc_busy,
    input wire logic comparator_one_en,
    input wire logic comparator_two_en,
    // from bench
    input wire logic [11:0] level,
    input wire logic [1:0] cmp_level,
    // to design
    output logic [11:0] adc_data,
    output logic comparator_one,
    output logic comparator_two
);
    // result only valid while converting
    assign adc_data = adc_busy ? level : ~level;
    // a disabled comparator rests low
    assign comparator_one = comparator_one_en & cmp_level[0];
    assign comparator_two = comparator_two_en & cmp_level[1];
endmodule : acc_analog_model
`default_nettype wire

// File: dv/tb_analog_converter_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_analog_converter_control;
    import acc_pkg::*;
    logic clock = 0, reset = 1, src_16m_tick = 0, avs_read = 0, avs_write = 0, wk = 0, sm;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q, r, seed = 32'h2f3e;
    logic avs_waitrequest, conv_clk, ref_sel, adc_gain, adc_sample, adc_busy, supply_mon_en;
    logic analog_output_one_en, analog_output_one_range, analog_output_one_busy;
    logic analog_output_two_en, analog_output_two_range, analog_output_two_busy;
    logic comparator_one_en, comparator_two_en, cmp_low_power, adc_irq, cmp_irq, cmp_wake;
    logic comparator_one, comparator_two;
    logic [2:0] adc_chan;
    logic [11:0] adc_data, analog_output_one_code, analog_output_two_code, level = 0;
    logic [1:0] comparator_one_negative_input, comparator_two_negative_input, cmp_hysteresis, cmp_level = 0;
    int errors = 0, compares = 0, n, s, tc = 0, e;
    acc_converter_control u_acc_converter_control (.clock_en(1'b1), .avs_byteenable(4'hf), .*);
    acc_analog_model u_acc_analog_model (.*);
    always #5 clock = ~clock;
    always @(posedge clock) begin
        tc <= (tc == 5) ? 0 : tc + 1;
        src_16m_tick <= (tc == 5);
        if (cmp_wake === 1'b1) wk <= 1'b1;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0 && ++k < 100);
        if (avs_waitrequest !== 1'b0) errors++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        compares++;
        if (y !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    task print_verdict();
        if (errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        #500us;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        bus(0, ACC_OFS_CTRL, 0);
        chk("ctrl reset", 0, q);
        bus(0, 8'hfc, 0);
        chk("unmapped", 0, q);
        for (s = 0; s < 4; s++) begin
            r = xs();
            level <= r[11:0];
            bus(1, ACC_OFS_CTRL, (s << 4) | ((s + 2) << 11) | ((s & 1) << 7) | (r[13:12] << 2));
            chk("ctrl pins", {r[12], r[13], 3'(s + 2)}, {ref_sel, adc_gain, adc_chan});
            bus(1, ACC_OFS_START, 1);
            sm = 1;
            n = 0;
            while (adc_busy !== 1'b0 && n < 9000) begin
                sm &= (supply_mon_en === (s == 3)) && (n > 0 || adc_sample === 1'b1);
                @(posedge clock);
                n++;
            end
            e = 3 * (2 * s + 2);
            chk("duration", 1, n >= (e + 13) * 48 && n <= (e + 14) * 48 + 2);
            chk("supply and sample", 1, sm);
            chk("irq", s & 1, adc_irq);
            bus(0, ACC_OFS_ADC_RES, 0);
            chk("result", r[11:0], q);
            bus(0, ACC_OFS_STAT, 0);
            chk("eoc", 1, q[1]);
            bus(1, ACC_OFS_STAT, 2);
            chk("irq clear", 0, adc_irq);
        end
        r = xs() | 32'hf00;
        level <= r[11:0];
        bus(1, ACC_OFS_CTRL, 32'h7c0);
        bus(1, ACC_OFS_START, 1);
        n = 0;
        while (adc_irq !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        chk("acc timing", 1, n >= 15 * 20 * 48 && n <= 16 * 20 * 48 + 4);
        bus(0, ACC_OFS_ACC_RES, 0);
        chk("acc", 16 * r[11:0], q);
        bus(1, ACC_OFS_CTRL, 0);
        bus(1, ACC_OFS_DAC_CTRL, 32'hd);
        r = xs();
        bus(1, ACC_OFS_OUT_ONE_VAL, r[11:0]);
        bus(1, ACC_OFS_OUT_TWO_VAL, r[23:12]);
        chk("dac busy", 3, {analog_output_two_busy, analog_output_one_busy});
        chk("dac code", r[23:0], {analog_output_two_code, analog_output_one_code});
        chk("dac range", 2, {analog_output_two_range, analog_output_one_range});
        n = 0;
        while (analog_output_one_busy === 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        chk("dac period", 1, n >= 19 * 48 - 8 && n <= 20 * 48);
        bus(1, ACC_OFS_OUT_ONE_VAL, r[23:12]);
        bus(1, ACC_OFS_DAC_CTRL, 0);
        chk("dac off", 0, {analog_output_two_busy, analog_output_one_busy, analog_output_one_en});
        bus(1, ACC_OFS_CMP_CTRL, 32'h7f9e);
        chk("cmp cfg", 32'h137, {cmp_hysteresis, comparator_one_negative_input, comparator_two_negative_input,
            cmp_low_power, comparator_two_en, comparator_one_en});
        cmp_level <= 2'h1;
        repeat (2) @(posedge clock);
        chk("sync", 0, cmp_irq);
        repeat (4) @(posedge clock);
        chk("cmp irq", 1, cmp_irq);
        bus(0, ACC_OFS_STAT, 0);
        chk("cmp stat", 5, q[7:4]);
        chk("wake", 1, wk);
        print_verdict();
    end
endmodule : tb_analog_converter_control
`default_nettype wire
